// [common/sffe_consts.vh]
// constants for the serial frame engine
// Summary of operation
// - clock rests at polarity level when idle
// - phase picks first or second sampling edge
// - idle: select high, transmit line low
// - idle clock driver on for master only
// - master drops select when enabled with data
// - master enables transmit driver at start
// - mode 00: data half period before clock
// - mode 00: sample rising, change falling
// - mode 01: clock starts rising, sample falling
// - mode 10: sample falling, change rising
// - mode 11: clock starts falling, sample rising
// - select rises one bit after last sample
// - phase 0: select pulses high between words
// - phase 0 slave reloads only after select rises
// - phase 1: select stays low across words
// - words 4 to 16 bits, msb first
// - bit clock: even prescale times rate plus one
// - eight-deep sixteen-bit fifos; received words stored
`ifndef SFFE_CONSTS_VH
`define SFFE_CONSTS_VH
`define SFFE_ADDR_W      4
`define SFFE_REG_CTRL0   4'h0
`define SFFE_REG_CTRL1   4'h1
`define SFFE_REG_DATA    4'h2
`define SFFE_REG_STATUS  4'h3
`define SFFE_REG_PRESC   4'h4
`define SFFE_DSS_LO      3:0
`define SFFE_SPO_BIT     6
`define SFFE_SPH_BIT     7
`define SFFE_SCR_RANGE   15:8
`define SFFE_SSE_BIT     1
`define SFFE_MS_BIT      2
`define SFFE_DSS_MIN     4'h3
`define SFFE_FIFO_DEPTH  32
`define SFFE_FIFO_AW     5
`define SFFE_WORD_W      16
`define SFFE_HW_FIFO_MAX 6'h08
`define SFFE_PRESC_MIN   8'h02
`define SFFE_ST_IDLE     3'h0
`define SFFE_ST_LEAD     3'h1
`define SFFE_ST_BITA     3'h2
`define SFFE_ST_BITB     3'h3
`define SFFE_ST_TAIL     3'h4
`define SFFE_ST_GAP      3'h5
`endif

// [sim/sffe_engine_asserts.sv]
// assertion checker bound to the serial frame engine top
// ==========================================
// checker
module sffe_engine_asserts (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        clk_en,
  // register port
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  // serial pins
  input wire logic        serial_bit_clock_pin_o,
  input wire logic        serial_bit_clock_pin_oe,
  input wire logic        frame_select_pin_o,
  input wire logic        serial_transmit_line,
  input wire logic        serial_transmit_line_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  rate_r;
  logic [7:0]  presc_r;
  logic [3:0]  sz_r;
  logic        pol_r;
  logic        pha_r;
  logic        en_r;
  logic        slv_r;
  logic        clk_q;
  logic [1:0]  age_r;
  logic [15:0] gap_r;
  logic [15:0] tog_cnt_r;
  wire         tog   = serial_bit_clock_pin_o != clk_q;
  wire         run   = en_r && !slv_r;
  wire  [4:0]  nbits = {1'b0, sz_r} + 5'h01;
  wire  [15:0] bits2 = {10'h000, nbits, 1'b0};
  wire  [15:0] half  = ((presc_r < 8'h02) ? 16'h0001 : {9'h000, presc_r[7:1]}) * ({8'h00, rate_r} + 16'h0001);
  // shadow of the settings, cycles since a clock edge, edges within a frame
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {rate_r, presc_r, sz_r, pol_r, pha_r, en_r, slv_r, clk_q, age_r} <= '0;
      gap_r <= 16'h0000;
      tog_cnt_r <= 16'h0000;
    end else begin
      clk_q <= serial_bit_clock_pin_o;
      gap_r <= tog ? 16'h0001 : gap_r + {15'h0000, gap_r != 16'hFFFF};
      tog_cnt_r <= frame_select_pin_o ? 16'h0000 : tog_cnt_r + {15'h0000, tog};
      age_r <= age_r + {1'b0, age_r != 2'h3};
      if (reg_wr && clk_en && reg_addr == 4'h0) begin
        {rate_r, pha_r, pol_r, sz_r} <= {reg_wdata[15:6], reg_wdata[3:0]};
        age_r <= 2'h0;
      end
      if (reg_wr && clk_en && reg_addr == 4'h1) begin
        {slv_r, en_r} <= reg_wdata[2:1];
        age_r <= 2'h0;
      end
      if (reg_wr && clk_en && reg_addr == 4'h4)
        presc_r <= reg_wdata[7:0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // select resting high for three cycles
  sequence sel_idle3;
    frame_select_pin_o [*3];
  endsequence
  // select dropping to open a frame
  sequence sel_start;
    $fell(frame_select_pin_o);
  endsequence
  idle_clock_level_a: assert property (sel_idle3 ##0 age_r == 2'h3 |-> serial_bit_clock_pin_o == pol_r)
    else $error("serial clock not at its resting level");
  idle_tx_low_a: assert property (sel_idle3 ##0 !slv_r |-> !serial_transmit_line)
    else $error("transmit line not low while idle");
  clock_drive_a: assert property (age_r == 2'h3 |-> serial_bit_clock_pin_oe == run)
    else $error("clock driver enable wrong for the role");
  start_prompt_a: assert property (reg_wr && clk_en && reg_addr == 4'h2 && run && sz_r >= 4'h3 && age_r == 2'h3
    |-> ##[1:300] !frame_select_pin_o)
    else $error("queued word did not open a frame");
  start_drive_a: assert property (sel_start |-> ##[0:1] serial_transmit_line_oe)
    else $error("transmit driver off at frame start");
  edge_spacing_a: assert property (tog && !frame_select_pin_o && run && (tog_cnt_r % bits2) != 16'h0000
    |-> gap_r == half)
    else $error("clock edges not one half bit apart");
  frame_end_a: assert property ($rose(frame_select_pin_o) && run
    |-> {1'b0, gap_r} == (pha_r ? {half, 1'b0} : {1'b0, half}))
    else $error("select rose at the wrong time after the last sample");
  word_pulse_a: assert property (!frame_select_pin_o && run && !pha_r |-> tog_cnt_r <= bits2)
    else $error("phase 0 frame ran past one word");
endmodule

bind sffe_engine sffe_engine_asserts u_chk (
  .sys_clk                 (sys_clk),
  .sys_rst                 (sys_rst),
  .clk_en                  (clk_en),
  .reg_addr                (reg_addr),
  .reg_wdata               (reg_wdata),
  .reg_wr                  (reg_wr),
  .serial_bit_clock_pin_o  (serial_bit_clock_pin_o),
  .serial_bit_clock_pin_oe (serial_bit_clock_pin_oe),
  .frame_select_pin_o      (frame_select_pin_o),
  .serial_transmit_line    (serial_transmit_line),
  .serial_transmit_line_oe (serial_transmit_line_oe)
);

// [sim/sffe_peer_model.sv]
// behavioural serial peripheral on the far side of the frame engine
module sffe_peer_model (
  // serial wires
  input  wire logic        sclk,
  input  wire logic        ssel_n,
  input  wire logic        mosi,
  output logic             miso,
  // setup and observation
  input  wire logic        pol,
  input  wire logic        pha,
  input  wire logic [4:0]  nbits,
  input  wire logic [15:0] reply,
  output logic      [15:0] got
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] idx;
  // quiet start
  initial begin
    miso = 1'b0;
    got = 16'h0000;
    idx = 5'h00;
  end
  // select falling loads the word; phase 0 shows its msb at once
  always @(negedge ssel_n) begin
    got = 16'h0000;
    idx = pha ? nbits : nbits - 5'h01;
    if (!pha)
      miso = reply[idx[3:0]];
  end
  // a released line shows the inverse of its last value
  always @(posedge ssel_n)
    miso = ~miso;
  // leading edge samples in phase 0, trailing edge in phase 1
  always @(sclk) begin
    if (!ssel_n && ((sclk != pol) ^ pha))
      got = {got[14:0], mosi};
    else if (!ssel_n) begin
      idx = (idx == 5'h00) ? nbits - 5'h01 : idx - 5'h01;
      miso = reply[idx[3:0]];
    end
  end
endmodule

// [sim/test_spi_frame_format_engine.sv]
// self-checking bench for the serial frame engine
module test_spi_frame_format_engine;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk;
  logic        sys_rst;
  logic        reg_wr;
  logic        reg_rd;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] rd;
  logic [15:0] reply;
  logic [4:0]  nbits;
  logic        pol;
  logic        pha;
  wire  [15:0] reg_rdata;
  wire  [15:0] got;
  wire         sclk_o;
  wire         sclk_oe;
  wire         sel_o;
  wire         sel_oe;
  wire         mosi;
  wire         tx_oe;
  wire         miso;
  int          fail_count;
  int          checked;
  int          rises;
  // wire levels: undriven clock rests at polarity, select pulled up
  wire         sclk_w = sclk_oe ? sclk_o : pol;
  wire         sel_w  = sel_oe ? sel_o : 1'b1;
  sffe_engine DUT (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_bit_clock_pin_i(sclk_w), .serial_bit_clock_pin_o(sclk_o), .serial_bit_clock_pin_oe(sclk_oe),
    .frame_select_pin_i(sel_w), .frame_select_pin_o(sel_o), .frame_select_pin_oe(sel_oe),
    .serial_transmit_line(mosi), .serial_transmit_line_oe(tx_oe), .serial_receive_line(miso)
  );
  sffe_peer_model peer (
    .sclk(sclk_w), .ssel_n(sel_w), .mosi(mosi), .miso(miso),
    .pol(pol), .pha(pha), .nbits(nbits), .reply(reply), .got(got)
  );
  // 25 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // count select rises on the wire
  always @(posedge sel_w)
    rises++;
  task automatic check(input bit ok, input string msg);
    checked++;
    if (!ok) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  // disable, set prescale 2 and rate 3, then enable as master
  // a four-clock half bit leaves room for the receive synchroniser
  task automatic setup(input logic p, input logic h, input logic [3:0] sz, input logic [15:0] rp);
    pol = p;
    pha = h;
    nbits = {1'b0, sz} + 5'h01;
    reply = rp;
    wr(4'h1, 16'h0000);
    wr(4'h4, 16'h0002);
    wr(4'h0, {8'h03, h, p, 2'b00, sz});
    wr(4'h1, 16'h0002);
  endtask
  task automatic wait_idle;
    int n = 0;
    rdr(4'h3);
    while (!(rd[4] === 1'b0 && rd[0] === 1'b1) && n < 2000) begin
      rdr(4'h3);
      n++;
    end
    check(n < 2000, "transfer never finished");
    if (n >= 2000)
      wrap_up;
    repeat (8) @(posedge sys_clk);
  endtask
  // all four modes plus the shortest and longest word
  task automatic t_modes;
    logic [3:0]  szs [6] = '{4'h7, 4'h7, 4'h7, 4'h7, 4'h3, 4'hF};
    logic [15:0] mask;
    for (int i = 0; i < 6; i++) begin
      mask = 16'hFFFF >> (4'hF - szs[i]);
      setup(i[1], i[0], szs[i], 16'h5AC3);
      wr(4'h2, 16'hC3A5);
      wait_idle;
      check(got === (16'hC3A5 & mask), "word seen by peer");
      rdr(4'h2);
      check(rd === (16'h5AC3 & mask), "received word");
      check(sclk_o === pol && mosi === 1'b0, "idle levels");
    end
    $display("modes done");
  endtask
  // two queued words: phase 0 pulses select, phase 1 holds it
  task automatic t_burst(input logic h);
    setup(1'b0, h, 4'h7, 16'h5AC3);
    rises = 0;
    wr(4'h2, 16'h0012);
    wr(4'h2, 16'h0034);
    wait_idle;
    check(rises === (h ? 1 : 2), "select rises in a burst");
    check(h ? got === 16'h1234 : got[7:0] === 8'h34, "burst words at peer");
    for (int i = 0; i < 2; i++) begin
      rdr(4'h2);
      check(rd === 16'h00C3, "burst word received");
    end
    $display("burst done");
  endtask
  // nine words into a stopped port, then drain both fifos
  task automatic t_fifo;
    setup(1'b0, 1'b0, 4'h7, 16'h5AC3);
    wr(4'h1, 16'h0000);
    for (int i = 0; i < 9; i++)
      wr(4'h2, 16'h0010 + i[15:0]);
    rdr(4'h3);
    check(rd[1:0] === 2'b00, "transmit fifo full");
    wr(4'h1, 16'h0002);
    wait_idle;
    check(got[7:0] === 8'h17, "ninth word dropped");
    rdr(4'h3);
    check(rd[3:2] === 2'b11, "receive fifo full");
    for (int i = 0; i < 9; i++) begin
      rdr(4'h2);
      check(rd === (i < 8 ? 16'h00C3 : 16'h0000), "receive fifo drain");
    end
    $display("fifo done");
  endtask
  // slave role leaves the clock and select undriven
  task automatic t_slave;
    wr(4'h1, 16'h0006);
    repeat (4) @(posedge sys_clk);
    check(sclk_oe === 1'b0 && sel_oe === 1'b0 && tx_oe === 1'b0, "slave drivers");
    wr(4'h1, 16'h0000);
    $display("slave done");
  endtask
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // reset for three cycles, then the scenarios
  initial begin
    sys_rst = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {pol, pha, reply, rd} = '0;
    nbits = 5'h08;
    {fail_count, checked, rises} = '0;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_modes;
    t_burst(1'b0);
    t_burst(1'b1);
    t_fifo;
    t_slave;
    wrap_up;
  end
endmodule

// [verilog/sffe_engine.v]
// serial frame engine with register port, fifos, master and slave roles
`include "sffe_consts.vh"
// ==========================================
// fifo with valid and ready on both sides
module sffe_fifo #(
  parameter WIDTH = `SFFE_WORD_W,
  parameter DEPTH = `SFFE_FIFO_DEPTH,
  parameter AW    = `SFFE_FIFO_AW
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst,
  input  wire             ce,
  // filling side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // draining side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0]      level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wp_r;
  reg [AW-1:0]    rp_r;
  reg [AW:0]      cnt_r;
  wire            wr_go;
  wire            rd_go;
  assign in_ready  = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data  = mem[rp_r];
  assign level     = cnt_r;
  assign wr_go     = ce & in_valid & in_ready;
  assign rd_go     = ce & out_valid & out_ready;
  // storage
  always @(posedge clk) begin
    if (wr_go) begin
      mem[wp_r] <= in_data;
    end
  end
  // pointers and count
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (wr_go) begin
        wp_r <= wp_r + 1'b1;
      end
      if (rd_go) begin
        rp_r <= rp_r + 1'b1;
      end
      if (wr_go & ~rd_go) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (rd_go & ~wr_go) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// ==========================================
// frame engine top
module sffe_engine (
  // clock and reset
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        clk_en,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  // serial pins
  input  wire        serial_bit_clock_pin_i,
  output reg         serial_bit_clock_pin_o,
  output reg         serial_bit_clock_pin_oe,
  input  wire        frame_select_pin_i,
  output reg         frame_select_pin_o,
  output reg         frame_select_pin_oe,
  output reg         serial_transmit_line,
  output reg         serial_transmit_line_oe,
  input  wire        serial_receive_line
);
  // ==========================================
  // registers
  reg  [15:0] control_register_zero_r;
  reg  [2:0]  control_one_r;
  reg  [7:0]  clock_prescale_divisor_r;
  reg         busy_r;
  wire [3:0]  dss        = control_register_zero_r[`SFFE_DSS_LO];
  wire        clock_polarity_bit = control_register_zero_r[`SFFE_SPO_BIT];
  wire        clock_phase_bit    = control_register_zero_r[`SFFE_SPH_BIT];
  wire [7:0]  serial_clock_rate_field = control_register_zero_r[`SFFE_SCR_RANGE];
  wire        port_en    = control_one_r[`SFFE_SSE_BIT];
  wire        is_slave   = control_one_r[`SFFE_MS_BIT];
  wire        dss_ok     = (dss >= `SFFE_DSS_MIN);
  // fifo wires
  wire        tx_in_rdy;
  wire        tx_out_vld;
  wire [15:0] tx_out_dat;
  wire [5:0]  tx_lvl;
  wire        rx_in_rdy;
  wire        rx_out_vld;
  wire [15:0] rx_out_dat;
  wire [5:0]  rx_lvl;
  reg         tx_pop;
  reg         rx_push;
  reg  [15:0] rx_word_r;
  wire        wr_data = reg_wr & (reg_addr == `SFFE_REG_DATA);
  wire        rd_data = reg_rd & (reg_addr == `SFFE_REG_DATA);
  // software writes beyond the eight documented entries are refused
  wire        tx_accept = wr_data & tx_in_rdy & (tx_lvl < `SFFE_HW_FIFO_MAX);

  sffe_fifo #(.WIDTH(16), .DEPTH(`SFFE_FIFO_DEPTH), .AW(`SFFE_FIFO_AW)) u_txf (
    .clk       (sys_clk),
    .rst       (sys_rst),
    .ce        (clk_en),
    .in_valid  (tx_accept),
    .in_ready  (tx_in_rdy),
    .in_data   (reg_wdata),
    .out_valid (tx_out_vld),
    .out_ready (tx_pop),
    .out_data  (tx_out_dat),
    .level     (tx_lvl)
  );
  sffe_fifo #(.WIDTH(16), .DEPTH(`SFFE_FIFO_DEPTH), .AW(`SFFE_FIFO_AW)) u_rxf (
    .clk       (sys_clk),
    .rst       (sys_rst),
    .ce        (clk_en),
    .in_valid  (rx_push & rx_in_rdy & (rx_lvl < `SFFE_HW_FIFO_MAX)),
    .in_ready  (rx_in_rdy),
    .in_data   (rx_word_r),
    .out_valid (rx_out_vld),
    .out_ready (rd_data),
    .out_data  (rx_out_dat),
    .level     (rx_lvl)
  );

  // register writes and read data
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      control_register_zero_r  <= 16'h0000;
      control_one_r            <= 3'h0;
      clock_prescale_divisor_r <= 8'h00;
      reg_rdata                <= 16'h0000;
    end else if (clk_en) begin
      if (reg_wr) begin
        case (reg_addr)
          `SFFE_REG_CTRL0: control_register_zero_r <= reg_wdata;
          `SFFE_REG_CTRL1: control_one_r <= reg_wdata[2:0];
          `SFFE_REG_PRESC: clock_prescale_divisor_r <= {reg_wdata[7:1], 1'b0};
          default: ;
        endcase
      end
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        case (reg_addr)
          `SFFE_REG_CTRL0:  reg_rdata <= control_register_zero_r;
          `SFFE_REG_CTRL1:  reg_rdata <= {13'h0000, control_one_r};
          `SFFE_REG_DATA:   reg_rdata <= rx_out_vld ? rx_out_dat : 16'h0000;
          `SFFE_REG_STATUS: reg_rdata <= {11'h000, busy_r, rx_lvl == `SFFE_HW_FIFO_MAX, rx_out_vld,
                                          tx_lvl < `SFFE_HW_FIFO_MAX, ~tx_out_vld};
          `SFFE_REG_PRESC:  reg_rdata <= {8'h00, clock_prescale_divisor_r};
          default:          reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // ==========================================
  // pin synchronisers
  reg [1:0] sclk_s_r;
  reg [1:0] fss_s_r;
  reg [1:0] rxd_s_r;
  reg       sclk_d_r;
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_s_r <= 2'b00;
      fss_s_r  <= 2'b11;
      rxd_s_r  <= 2'b00;
      sclk_d_r <= 1'b0;
    end else if (clk_en) begin
      sclk_s_r <= {sclk_s_r[0], serial_bit_clock_pin_i};
      fss_s_r  <= {fss_s_r[0], frame_select_pin_i};
      rxd_s_r  <= {rxd_s_r[0], serial_receive_line};
      sclk_d_r <= sclk_s_r[1];
    end
  end
  wire rxd    = rxd_s_r[1];
  wire s_sel  = ~fss_s_r[1];
  wire s_rise = sclk_s_r[1] & ~sclk_d_r;
  wire s_fall = ~sclk_s_r[1] & sclk_d_r;
  // slave sample and change edges per polarity and phase
  wire s_samp = (clock_polarity_bit ^ clock_phase_bit) ? s_fall : s_rise;
  wire s_chg  = (clock_polarity_bit ^ clock_phase_bit) ? s_rise : s_fall;

  // ==========================================
  // half-bit tick: prescale then rate field
  reg  [7:0]  pre_cnt_r;
  reg  [7:0]  rate_cnt_r;
  reg         half_tick;
  reg  [2:0]  state_r;
  reg  [3:0]  bit_r;
  reg  [15:0] sh_tx_r;
  reg  [15:0] sh_rx_r;
  wire        run = (state_r != `SFFE_ST_IDLE);
  wire [7:0]  presc_half = clock_prescale_divisor_r < `SFFE_PRESC_MIN ?
                           8'h01 : {1'b0, clock_prescale_divisor_r[7:1]};
  // a half bit is presc/2 * (1 + rate) system clocks
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_cnt_r  <= 8'h00;
      rate_cnt_r <= 8'h00;
      half_tick  <= 1'b0;
    end else if (clk_en) begin
      half_tick <= 1'b0;
      if (!run) begin
        pre_cnt_r  <= 8'h00;
        rate_cnt_r <= 8'h00;
      end else if (pre_cnt_r == presc_half - 8'h01) begin
        pre_cnt_r <= 8'h00;
        if (rate_cnt_r == serial_clock_rate_field) begin
          rate_cnt_r <= 8'h00;
          half_tick  <= 1'b1;
        end else begin
          rate_cnt_r <= rate_cnt_r + 8'h01;
        end
      end else begin
        pre_cnt_r <= pre_cnt_r + 8'h01;
      end
    end
  end

  // ==========================================
  // frame sequencer (master) and shifter (slave)
  wire [15:0] msb_mask = 16'h0001 << dss;
  wire [15:0] word_mask = {msb_mask[14:0], 1'b0} - 16'h0001;
  wire        m_start  = port_en & ~is_slave & tx_out_vld & dss_ok & (state_r == `SFFE_ST_IDLE);
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r                 <= `SFFE_ST_IDLE;
      bit_r                   <= 4'h0;
      sh_tx_r                 <= 16'h0000;
      sh_rx_r                 <= 16'h0000;
      rx_word_r               <= 16'h0000;
      rx_push                 <= 1'b0;
      tx_pop                  <= 1'b0;
      busy_r                  <= 1'b0;
      serial_bit_clock_pin_o  <= 1'b0;
      serial_bit_clock_pin_oe <= 1'b0;
      frame_select_pin_o      <= 1'b1;
      frame_select_pin_oe     <= 1'b0;
      serial_transmit_line    <= 1'b0;
      serial_transmit_line_oe <= 1'b0;
    end else if (clk_en) begin
      rx_push <= 1'b0;
      tx_pop  <= 1'b0;
      serial_bit_clock_pin_oe <= port_en & ~is_slave;
      frame_select_pin_oe     <= port_en & ~is_slave;
      if (!port_en) begin
        state_r                 <= `SFFE_ST_IDLE;
        busy_r                  <= 1'b0;
        serial_bit_clock_pin_o  <= clock_polarity_bit;
        frame_select_pin_o      <= 1'b1;
        serial_transmit_line    <= 1'b0;
        serial_transmit_line_oe <= 1'b0;
      end else if (is_slave) begin
        serial_bit_clock_pin_o <= clock_polarity_bit;
        frame_select_pin_o     <= 1'b1;
        serial_transmit_line_oe <= s_sel;
        busy_r <= s_sel;
        if (!s_sel) begin
          // word loads only while deselected when phase is 0
          serial_transmit_line <= 1'b0;
          bit_r <= dss;
          if (tx_out_vld && !tx_pop && state_r == `SFFE_ST_IDLE) begin
            sh_tx_r <= tx_out_dat;
            tx_pop  <= 1'b1;
            state_r <= `SFFE_ST_BITA;
          end
        end else begin
          if (state_r == `SFFE_ST_BITA && !clock_phase_bit) begin
            serial_transmit_line <= |(sh_tx_r & msb_mask);
          end
          if (s_chg && !(clock_phase_bit && bit_r == dss && state_r != `SFFE_ST_BITB)) begin
            serial_transmit_line <= |(sh_tx_r & msb_mask);
          end
          if (s_chg && state_r == `SFFE_ST_BITB) begin
            sh_tx_r <= {sh_tx_r[14:0], 1'b0};
          end
          if (s_chg && clock_phase_bit) begin
            state_r <= `SFFE_ST_BITB;
            serial_transmit_line <= |(sh_tx_r & msb_mask);
          end
          if (s_samp) begin
            sh_rx_r <= {sh_rx_r[14:0], rxd};
            if (!clock_phase_bit) begin
              state_r <= `SFFE_ST_BITB;
            end
            if (bit_r == 4'h0) begin
              rx_word_r <= {sh_rx_r[14:0], rxd} & word_mask;
              rx_push   <= 1'b1;
              bit_r     <= dss;
              state_r   <= clock_phase_bit ? `SFFE_ST_BITA : `SFFE_ST_GAP;
              if (clock_phase_bit && tx_out_vld) begin
                sh_tx_r <= tx_out_dat;
                tx_pop  <= 1'b1;
              end
            end else begin
              bit_r <= bit_r - 4'h1;
            end
          end
        end
      end else begin
        case (state_r)
          `SFFE_ST_IDLE: begin
            busy_r                  <= 1'b0;
            serial_bit_clock_pin_o  <= clock_polarity_bit;
            frame_select_pin_o      <= 1'b1;
            serial_transmit_line    <= 1'b0;
            serial_transmit_line_oe <= 1'b0;
            if (m_start) begin
              sh_tx_r                 <= tx_out_dat;
              tx_pop                  <= 1'b1;
              bit_r                   <= dss;
              busy_r                  <= 1'b1;
              frame_select_pin_o      <= 1'b0;
              serial_transmit_line_oe <= 1'b1;
              state_r                 <= `SFFE_ST_LEAD;
            end
          end
          `SFFE_ST_LEAD: begin
            // half bit after select falls: data out; first edge here in phase 1, a half bit later in phase 0
            if (half_tick) begin
              serial_transmit_line <= |(sh_tx_r & msb_mask);
              if (clock_phase_bit) begin
                serial_bit_clock_pin_o <= ~clock_polarity_bit;
                state_r <= `SFFE_ST_BITB;
              end else begin
                state_r <= `SFFE_ST_BITA;
              end
            end
          end
          `SFFE_ST_BITA: begin
            // first edge of bit: sample for phase 0
            if (half_tick) begin
              serial_bit_clock_pin_o <= ~serial_bit_clock_pin_o;
              if (!clock_phase_bit) begin
                sh_rx_r <= {sh_rx_r[14:0], rxd};
              end else begin
                serial_transmit_line <= |(sh_tx_r & msb_mask);
              end
              state_r <= `SFFE_ST_BITB;
            end
          end
          `SFFE_ST_BITB: begin
            // second edge: sample for phase 1, else change data
            if (half_tick) begin
              serial_bit_clock_pin_o <= ~serial_bit_clock_pin_o;
              if (clock_phase_bit) begin
                sh_rx_r <= {sh_rx_r[14:0], rxd};
              end
              if (bit_r == 4'h0) begin
                rx_word_r <= (clock_phase_bit ? {sh_rx_r[14:0], rxd} : sh_rx_r) & word_mask;
                rx_push   <= 1'b1;
                if (clock_phase_bit && tx_out_vld && !tx_pop) begin
                  sh_tx_r <= tx_out_dat;
                  tx_pop  <= 1'b1;
                  bit_r   <= dss;
                  state_r <= `SFFE_ST_BITA;
                end else begin
                  bit_r   <= {3'h0, clock_phase_bit};
                  state_r <= `SFFE_ST_TAIL;
                end
              end else begin
                sh_tx_r <= {sh_tx_r[14:0], 1'b0};
                bit_r   <= bit_r - 4'h1;
                if (!clock_phase_bit) begin
                  serial_transmit_line <= |({sh_tx_r[14:0], 1'b0} & msb_mask);
                end
                state_r <= `SFFE_ST_BITA;
              end
            end
          end
          `SFFE_ST_TAIL: begin
            // one full bit after last sample; phase 1 counts one more half bit
            if (half_tick && bit_r != 4'h0) begin
              bit_r <= bit_r - 4'h1;
            end else if (half_tick) begin
              frame_select_pin_o      <= 1'b1;
              serial_transmit_line    <= 1'b0;
              state_r <= (!clock_phase_bit && tx_out_vld) ? `SFFE_ST_GAP : `SFFE_ST_IDLE;
            end
          end
          `SFFE_ST_GAP: begin
            // select high pulse between phase 0 words
            if (half_tick) begin
              sh_tx_r            <= tx_out_dat;
              tx_pop             <= 1'b1;
              bit_r              <= dss;
              frame_select_pin_o <= 1'b0;
              state_r            <= `SFFE_ST_LEAD;
            end
          end
          default: state_r <= `SFFE_ST_IDLE;
        endcase
      end
    end
  end
endmodule
